// *** logic/ocp_pkg.sv ***
package ocp_pkg;
  localparam int          CORE_CHANNELS = 4;
  localparam int          INT_CHANNELS  = 2;
  localparam int          MAX_ATTEMPTS  = 7;
  localparam int          CLK_MHZ       = 125;
  localparam int          WAIT_MS       = 12;
  localparam int          WAIT_CYCLES   = WAIT_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W         = 21;
  localparam logic [2:0]  ATT_RESET     = 3'h0;

  typedef enum {
    ST_OFF,
    ST_SOFT,
    ST_RUN,
    ST_WAIT,
    ST_LATCH
  } rail_state_e;

  // Comparator results for one rail
  typedef struct packed {
    logic trip_normal;
    logic trip_boost;
  } trip_s;

  typedef struct packed {
    logic upper;
    logic lower;
  } gate_s;
endpackage

// *** logic/rail_retry.sv ***
`timescale 1ns/10ps
module rail_retry #(
  parameter int WAIT_LEN = ocp_pkg::WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // Control
  input  wire logic           enable,
  input  wire logic           soft_done,
  input  wire logic           kill,
  input  wire ocp_pkg::trip_s trip,
  // Status
  output logic                run_ok,
  output logic                in_soft,
  output logic                shut,
  output logic                exhausted
);
  ocp_pkg::rail_state_e state;
  ocp_pkg::rail_state_e next_state;
  logic [ocp_pkg::CNT_W-1:0] cnt;
  logic [ocp_pkg::CNT_W-1:0] next_cnt;
  logic [2:0]                att;
  logic [2:0]                next_att;
  logic                      trip_now;

  // Boosted level only while ramping
  always_comb
  begin
    trip_now = (state == ocp_pkg::ST_SOFT) ? trip.trip_boost : trip.trip_normal;
  end

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_att   = att;
    case (state)
      ocp_pkg::ST_OFF:
      begin
        next_att = ocp_pkg::ATT_RESET;
        if (enable)
          next_state = ocp_pkg::ST_SOFT;
      end
      ocp_pkg::ST_SOFT, ocp_pkg::ST_RUN:
      begin
        if (!enable)
          next_state = ocp_pkg::ST_OFF;
        else if (trip_now)
        begin
          if (att == 3'(ocp_pkg::MAX_ATTEMPTS))
            next_state = ocp_pkg::ST_LATCH;
          else
          begin
            next_state = ocp_pkg::ST_WAIT;
            next_att   = att + 3'h1;
            next_cnt   = ocp_pkg::CNT_W'(WAIT_LEN - 1);
          end
        end
        else if (state == ocp_pkg::ST_SOFT && soft_done)
        begin
          next_state = ocp_pkg::ST_RUN;
          next_att   = ocp_pkg::ATT_RESET;
        end
      end
      ocp_pkg::ST_WAIT:
      begin
        if (cnt != '0)
          next_cnt = cnt - 1'b1;
        else if (enable)
          next_state = ocp_pkg::ST_SOFT;
        else
          next_state = ocp_pkg::ST_OFF;
      end
      ocp_pkg::ST_LATCH:
        next_state = ocp_pkg::ST_LATCH;
      default:
        next_state = ocp_pkg::ST_OFF;
    endcase
    if (kill)
      next_state = ocp_pkg::ST_LATCH;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ocp_pkg::ST_OFF;
      cnt   <= '0;
      att   <= ocp_pkg::ATT_RESET;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      att   <= next_att;
    end
  end

  always_comb
  begin
    run_ok    = (state == ocp_pkg::ST_RUN);
    in_soft   = (state == ocp_pkg::ST_SOFT);
    shut      = (state != ocp_pkg::ST_SOFT) && (state != ocp_pkg::ST_RUN);
    exhausted = (state == ocp_pkg::ST_LATCH);
  end
endmodule // rail_retry

// *** logic/overcurrent_fault_sequencer.sv ***
`timescale 1ns/10ps
module overcurrent_fault_sequencer #(
  parameter int WAIT_LEN = ocp_pkg::WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               resetn,
  // Control inputs (asynchronous)
  input  wire logic                               enable,
  input  wire logic                               soft_done,
  input  wire logic                               core_volt_ok,
  input  wire logic                               nb_volt_ok,
  input  wire logic                               phase3_active,
  input  wire logic                               phase4_active,
  // Averaged current comparators (asynchronous)
  input  wire logic                               core_trip_normal,
  input  wire logic                               core_trip_boost,
  input  wire logic                               nb_trip_normal,
  input  wire logic                               nb_trip_boost,
  // Per-channel limit comparators (asynchronous)
  input  wire logic [ocp_pkg::CORE_CHANNELS-1:0]  channel_current_limit,
  // PWM requests from the modulator (same clock)
  input  wire logic [ocp_pkg::CORE_CHANNELS-1:0]  core_pwm,
  input  wire logic                               nb_pwm,
  // Gate drive outputs
  output logic [ocp_pkg::INT_CHANNELS-1:0]        upper_gate_drive,
  output logic [ocp_pkg::INT_CHANNELS-1:0]        lower_gate_drive,
  output logic                                    nb_upper_gate_drive,
  output logic                                    nb_lower_gate_drive,
  // External phase PWM pins
  output logic                                    ext_phase_pwm_third,
  output logic                                    ext_phase_pwm_third_oe,
  output logic                                    ext_phase_pwm_fourth,
  output logic                                    ext_phase_pwm_fourth_oe,
  // Status
  output logic                                    power_good_out,
  output logic                                    latched_off
);
  localparam int NSYNC = 9 + ocp_pkg::CORE_CHANNELS;

  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] filt;
  logic [NSYNC-1:0] next_filt;
  logic [NSYNC-1:0] raw;

  assign raw = {channel_current_limit, phase4_active, phase3_active, nb_volt_ok, core_volt_ok,
                nb_trip_boost, nb_trip_normal, core_trip_boost, core_trip_normal,
                enable};

  // Three stages; accept a change once stages two and three agree
  always_comb
  begin
    next_filt = filt;
    for (int i = 0; i < NSYNC; i++)
      if (s2[i] == s3[i])
        next_filt[i] = s3[i];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      filt <= '0;
    end
    else
    begin
      s1   <= raw;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  logic en_q;
  logic soft_done_q;
  logic [ocp_pkg::CORE_CHANNELS-1:0] limit_q;
  ocp_pkg::trip_s core_trip;
  ocp_pkg::trip_s nb_trip;

  // soft_done tracked separately below; enable on bit 0
  assign en_q      = filt[0];
  assign core_trip = '{trip_normal: filt[1], trip_boost: filt[2]};
  assign nb_trip   = '{trip_normal: filt[3], trip_boost: filt[4]};
  assign limit_q   = filt[NSYNC-1:9];

  logic sd1;
  logic sd2;
  logic sd3;
  logic next_sd;
  always_comb
  begin
    next_sd = soft_done_q;
    if (sd2 == sd3)
      next_sd = sd3;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sd1         <= 1'b0;
      sd2         <= 1'b0;
      sd3         <= 1'b0;
      soft_done_q <= 1'b0;
    end
    else
    begin
      sd1         <= soft_done;
      sd2         <= sd1;
      sd3         <= sd2;
      soft_done_q <= next_sd;
    end
  end

  logic core_run;
  logic core_soft;
  logic core_shut;
  logic core_dead;
  logic nb_run;
  logic nb_soft;
  logic nb_shut;
  logic nb_dead;

  // Either rail exhausting its attempts kills both
  rail_retry #(.WAIT_LEN(WAIT_LEN)) u_core (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (en_q),
    .soft_done (soft_done_q),
    .kill      (nb_dead),
    .trip      (core_trip),
    .run_ok    (core_run),
    .in_soft   (core_soft),
    .shut      (core_shut),
    .exhausted (core_dead)
  );

  rail_retry #(.WAIT_LEN(WAIT_LEN)) u_nb (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (en_q),
    .soft_done (soft_done_q),
    .kill      (core_dead),
    .trip      (nb_trip),
    .run_ok    (nb_run),
    .in_soft   (nb_soft),
    .shut      (nb_shut),
    .exhausted (nb_dead)
  );

  ocp_pkg::gate_s [ocp_pkg::CORE_CHANNELS-1:0] next_core;
  ocp_pkg::gate_s [ocp_pkg::CORE_CHANNELS-1:0] core_g;
  ocp_pkg::gate_s next_nb;
  logic [1:0]     next_oe;
  logic           next_pg;
  logic           next_latched;
  logic           core_off;
  logic           nb_off;

  always_comb
  begin
    // A latched rail takes the other down in the same cycle, not one later
    core_off = core_shut || nb_dead;
    nb_off   = nb_shut || core_dead;
    for (int c = 0; c < ocp_pkg::CORE_CHANNELS; c++)
    begin
      if (core_off)
        next_core[c] = '{upper: 1'b0, lower: 1'b0};
      else if (limit_q[c])
        next_core[c] = '{upper: 1'b0, lower: 1'b1};
      else
        next_core[c] = '{upper: core_pwm[c], lower: !core_pwm[c]};
    end
    if (nb_off)
      next_nb = '{upper: 1'b0, lower: 1'b0};
    else
      next_nb = '{upper: nb_pwm, lower: !nb_pwm};
    // Float external phases while shut so their drivers sit in tri-state
    next_oe[0] = filt[7] && !core_off;
    next_oe[1] = filt[8] && !core_off;
    next_pg    = core_run && nb_run && filt[5] && filt[6];
    next_latched = core_dead || nb_dead;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_g                  <= '0;
      nb_upper_gate_drive     <= 1'b0;
      nb_lower_gate_drive     <= 1'b0;
      ext_phase_pwm_third_oe  <= 1'b0;
      ext_phase_pwm_fourth_oe <= 1'b0;
      power_good_out          <= 1'b0;
      latched_off             <= 1'b0;
    end
    else
    begin
      core_g                  <= next_core;
      nb_upper_gate_drive     <= next_nb.upper;
      nb_lower_gate_drive     <= next_nb.lower;
      ext_phase_pwm_third_oe  <= next_oe[0];
      ext_phase_pwm_fourth_oe <= next_oe[1];
      power_good_out          <= next_pg;
      latched_off             <= next_latched;
    end
  end

  always_comb
  begin
    for (int c = 0; c < ocp_pkg::INT_CHANNELS; c++)
    begin
      upper_gate_drive[c] = core_g[c].upper;
      lower_gate_drive[c] = core_g[c].lower;
    end
    ext_phase_pwm_third  = core_g[2].upper;
    ext_phase_pwm_fourth = core_g[3].upper;
  end
endmodule // overcurrent_fault_sequencer

// *** bench/ocp_checker_assertions.sv ***
`timescale 1ns/10ps
module ocp_checker #(
  parameter int WAIT_LEN = ocp_pkg::WAIT_CYCLES
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Inputs
  input wire logic       core_volt_ok,
  input wire logic       core_trip_boost,
  input wire logic       nb_trip_boost,
  input wire logic [3:0] channel_current_limit,
  // Outputs
  input wire logic [1:0] upper_gate_drive,
  input wire logic [1:0] lower_gate_drive,
  input wire logic       nb_upper_gate_drive,
  input wire logic       nb_lower_gate_drive,
  input wire logic       ext_phase_pwm_third,
  input wire logic       ext_phase_pwm_third_oe,
  input wire logic       ext_phase_pwm_fourth_oe,
  input wire logic       power_good_out,
  input wire logic       latched_off
);
  int idle;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_core_off;
    upper_gate_drive == 2'h0 && lower_gate_drive == 2'h0 && !ext_phase_pwm_third_oe
      && !ext_phase_pwm_fourth_oe && !power_good_out;
  endsequence
  sequence s_gate_drop;
    |{upper_gate_drive, lower_gate_drive} ##1 {upper_gate_drive, lower_gate_drive} == 4'h0;
  endsequence
  // Starts full so the first start after reset is not taken for a retry
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      idle <= WAIT_LEN;
    else
      idle <= |{upper_gate_drive, lower_gate_drive} ? 0 : idle + 1;

  a_core_trip_stop: assert property (core_trip_boost[*8] |-> ##[0:8] s_core_off)
    else $error("core trip left the core stage on");
  a_nb_trip_stop: assert property (nb_trip_boost[*8] |-> ##[0:8]
    (!nb_upper_gate_drive && !nb_lower_gate_drive && !power_good_out))
    else $error("nb trip left the nb stage on");
  a_wait_hold: assert property (s_gate_drop |-> ({upper_gate_drive, lower_gate_drive} == 4'h0)[*8])
    else $error("core gates back too soon");
  a_wait_span: assert property
    (idle != 0 && |{upper_gate_drive, lower_gate_drive} |-> idle >= WAIT_LEN)
    else $error("core restart before wait ran out");
  a_latch_quiet: assert property (latched_off |-> s_core_off ##0
    (!nb_upper_gate_drive && !nb_lower_gate_drive))
    else $error("gates active while latched");
  a_latch_holds: assert property (latched_off |=> latched_off)
    else $error("latch released without reset");
  a_limit_upper: assert property (channel_current_limit[0][*8] |-> !upper_gate_drive[0])
    else $error("limited channel upper gate on");
  a_limit_ext: assert property (channel_current_limit[2][*8] |-> !ext_phase_pwm_third)
    else $error("limited external phase on");
  a_pg_volt: assert property (!core_volt_ok[*8] |-> !power_good_out)
    else $error("power good with core out of range");
endmodule // ocp_checker

bind overcurrent_fault_sequencer ocp_checker #(.WAIT_LEN(WAIT_LEN)) i_chk (
  .clk, .resetn, .core_volt_ok, .core_trip_boost, .nb_trip_boost, .channel_current_limit,
  .upper_gate_drive, .lower_gate_drive, .nb_upper_gate_drive, .nb_lower_gate_drive,
  .ext_phase_pwm_third, .ext_phase_pwm_third_oe, .ext_phase_pwm_fourth_oe,
  .power_good_out, .latched_off
);

// *** bench/power_stage_model.sv ***
`timescale 1ns/10ps
module power_stage_model #(
  parameter int LIM = 6
) (
  // Clock and switch activity
  input  wire logic       clk,
  input  wire logic [3:0] up,
  // Load set by the bench
  input  wire logic [1:0] core_load,
  input  wire logic [1:0] nb_load,
  // Comparators
  output logic            core_trip_normal,
  output logic            core_trip_boost,
  output logic            nb_trip_normal,
  output logic            nb_trip_boost,
  output logic [3:0]      channel_current_limit
);
  int cur [4];

  // Moderate load crosses only the normal level, a short both
  assign core_trip_normal = |core_load;
  assign core_trip_boost  = core_load[1];
  assign nb_trip_normal   = |nb_load;
  assign nb_trip_boost    = nb_load[1];
  // Current ramps while the upper switch conducts, decays otherwise
  always_ff @(posedge clk)
    for (int i = 0; i < 4; i++)
      cur[i] <= up[i] === 1'h1 ? cur[i] + 1 : (cur[i] > 0 ? cur[i] - 1 : 0);
  always_comb
    for (int i = 0; i < 4; i++)
      channel_current_limit[i] = cur[i] > LIM;
endmodule // power_stage_model

// *** bench/tb_overcurrent_fault_sequencer.sv ***
`timescale 1ns/10ps
module tb_overcurrent_fault_sequencer;
  localparam int WL = 20;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic enable = 1'h0;
  logic soft_done = 1'h0;
  logic core_volt_ok = 1'h0;
  logic nb_volt_ok = 1'h0;
  logic [1:0] core_load = 2'h0;
  logic [1:0] nb_load = 2'h0;
  // Held: phases present (t_start drops phase4_active once), modulator always asking for the upper switch
  logic phase3_active = 1'h1;
  logic phase4_active = 1'h1;
  logic [3:0] core_pwm = 4'hF;
  logic nb_pwm = 1'h1;
  logic core_trip_normal, core_trip_boost, nb_trip_normal, nb_trip_boost;
  logic [3:0] channel_current_limit, core_gates;
  logic [1:0] upper_gate_drive, lower_gate_drive;
  logic nb_upper_gate_drive, nb_lower_gate_drive, power_good_out, latched_off;
  logic ext_phase_pwm_third, ext_phase_pwm_third_oe;
  logic ext_phase_pwm_fourth, ext_phase_pwm_fourth_oe;
  int miscompares = 0;
  int total_checks = 0;

  assign core_gates = {upper_gate_drive, lower_gate_drive};
  always #4 clk = ~clk;

  overcurrent_fault_sequencer #(.WAIT_LEN(WL)) i_dut (
    .clk, .resetn, .enable, .soft_done, .core_volt_ok, .nb_volt_ok, .phase3_active,
    .phase4_active, .core_trip_normal, .core_trip_boost, .nb_trip_normal, .nb_trip_boost,
    .channel_current_limit, .core_pwm, .nb_pwm, .upper_gate_drive, .lower_gate_drive,
    .nb_upper_gate_drive, .nb_lower_gate_drive, .ext_phase_pwm_third,
    .ext_phase_pwm_third_oe, .ext_phase_pwm_fourth, .ext_phase_pwm_fourth_oe,
    .power_good_out, .latched_off
  );
  // Floated external pins carry no current
  power_stage_model i_stage (
    .clk, .core_load, .nb_load, .core_trip_normal, .core_trip_boost,
    .nb_trip_normal, .nb_trip_boost, .channel_current_limit,
    .up({ext_phase_pwm_fourth & ext_phase_pwm_fourth_oe,
      ext_phase_pwm_third & ext_phase_pwm_third_oe, upper_gate_drive})
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    resetn = 1'h0;
    {enable, soft_done, core_load, nb_load} = 6'h00;
    tick(4);
    chk({core_gates, power_good_out, latched_off}, 6'h00);
    resetn = 1'h1;
    enable = 1'h1;
    core_volt_ok = 1'h1;
    nb_volt_ok = 1'h1;
    tick(30);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 40 && core_gates != 4'h0; i++)
      tick(1);
  endtask
  task automatic wait_latch;
    for (int i = 0; i < 30 * WL && latched_off !== 1'h1; i++)
      tick(1);
  endtask
  task automatic t_start;
    do_reset();
    chk(power_good_out, 1'h0);
    soft_done = 1'h1;
    tick(20);
    chk(power_good_out, 1'h1);
    nb_volt_ok = 1'h0;
    tick(20);
    chk(power_good_out, 1'h0);
    nb_volt_ok = 1'h1;
    tick(20);
    chk(power_good_out, 1'h1);
    chk({ext_phase_pwm_third_oe, ext_phase_pwm_fourth_oe}, 2'h3);
    phase4_active = 1'h0;
    core_volt_ok = 1'h0;
    tick(20);
    chk(power_good_out, 1'h0);
    chk({ext_phase_pwm_third_oe, ext_phase_pwm_fourth_oe}, 2'h2);
    phase4_active = 1'h1;
    $display("t_start done");
  endtask
  task automatic t_hiccup;
    core_load = 2'h1;
    do_reset();
    core_load = 2'h1;
    // Soft start ignores a normal-level trip, so the gates must still be on after 20 cycles
    tick(20);
    chk(|core_gates, 1'h1);
    soft_done = 1'h1;
    repeat (9)
    begin
      wait_idle();
      chk({core_gates, power_good_out}, 5'h00);
      soft_done = 1'h0;
      tick(WL / 2);
      chk(|core_gates, 1'h0);
      tick(WL);
      chk(|core_gates, 1'h1);
      soft_done = 1'h1;
    end
    chk(latched_off, 1'h0);
    wait_idle();
    enable = 1'h0;
    tick(2 * WL);
    chk(|core_gates, 1'h0);
    $display("t_hiccup done");
  endtask
  task automatic t_latch;
    do_reset();
    soft_done = 1'h1;
    tick(20);
    core_load = 2'h2;
    wait_idle();
    soft_done = 1'h0;
    chk({core_gates, ext_phase_pwm_third_oe, ext_phase_pwm_fourth_oe, power_good_out}, 7'h00);
    tick(6 * WL);
    chk(latched_off, 1'h0);
    wait_latch();
    chk({latched_off, core_gates, nb_upper_gate_drive, nb_lower_gate_drive}, 7'h40);
    core_load = 2'h0;
    enable = 1'h0;
    tick(10);
    enable = 1'h1;
    tick(4 * WL);
    chk(latched_off, 1'h1);
    $display("t_latch done");
  endtask
  task automatic t_nb;
    do_reset();
    soft_done = 1'h1;
    tick(20);
    nb_load = 2'h2;
    for (int i = 0; i < 40 && nb_upper_gate_drive !== 1'h0; i++)
      tick(1);
    soft_done = 1'h0;
    chk({nb_upper_gate_drive, nb_lower_gate_drive, power_good_out, |core_gates}, 4'h1);
    wait_latch();
    chk({latched_off, core_gates}, 5'h10);
    $display("t_nb done");
  endtask
  task automatic t_limit;
    int lim;
    int lim1;
    int low4;
    int back;
    lim = 0;
    lim1 = 0;
    low4 = 0;
    back = 0;
    do_reset();
    soft_done = 1'h1;
    repeat (100)
    begin
      tick(1);
      lim += (upper_gate_drive[0] === 1'h0 && lower_gate_drive[0] === 1'h1);
      lim1 += (upper_gate_drive[1] === 1'h0 && lower_gate_drive[1] === 1'h1);
      low4 += (ext_phase_pwm_fourth_oe === 1'h1 && ext_phase_pwm_fourth === 1'h0);
      // Only a return after a limited stretch counts
      back += (lim > 0 && upper_gate_drive[0] === 1'h1);
    end
    chk(lim > 0, 1'h1);
    chk(lim1 > 0, 1'h1);
    chk(low4 > 0, 1'h1);
    chk(back > 0, 1'h1);
    chk(power_good_out, 1'h1);
    $display("t_limit done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    t_start();
    t_hiccup();
    t_latch();
    t_nb();
    t_limit();
    tally_and_finish();
  end
  // Whole run needs about 1200 cycles
  initial
  begin
    #(8 * 6000);
    miscompares++;
    tally_and_finish();
  end
endmodule // tb_overcurrent_fault_sequencer
